// *** shared/ssd_pkg.sv ***
// Constants, register map and carrier types for the spindle speed
// deviation monitor. Assumes a single 10 MHz APB clock domain.

package ssd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 32'h64;      // 100 ns
  localparam int unsigned MS_NS = 32'hf4240;           // 1 ms
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FUNC = 8'h00;
  localparam logic [7:0] OFS_PCT = 8'h04;
  localparam logic [7:0] OFS_DUR = 8'h08;
  localparam logic [7:0] OFS_MAG0 = 8'h0c;   // Four words, 0x0c..0x18
  localparam logic [7:0] OFS_MAG1 = 8'h10;
  localparam logic [7:0] OFS_MAG2 = 8'h14;
  localparam logic [7:0] OFS_MAG3 = 8'h18;
  localparam logic [7:0] OFS_SHIFT = 8'h1c;
  localparam logic [7:0] OFS_SPD_FULL = 8'h20;
  localparam logic [7:0] OFS_LOAD_VOLT = 8'h24;
  localparam logic [7:0] OFS_TOP_SPD = 8'h28;
  localparam logic [7:0] OFS_INT_STAT = 8'h2c;
  localparam logic [7:0] OFS_INT_MASK = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;

  // ----------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------
  localparam int unsigned FUNC_GAIN_CHG_BIT = 32'hc;
  localparam int unsigned FUNC_VTGT_BIT = 32'hd;
  localparam int unsigned INT_ALARM_SET_BIT = 32'h0;
  localparam int unsigned INT_ALARM_CLR_BIT = 32'h1;
  localparam logic [16:0] WIDTH_MIN_RPM = 17'h0002d;   // 45 r/min
  localparam logic [21:0] PCT_DIV = 22'h000064;        // 100
  localparam int unsigned MAG_SHIFT = 32'h8;           // 1/256 steps
  localparam logic [15:0] METER_FULL_CODE = 16'h7fff;  // 10 V
  localparam logic [7:0] LOAD_FULL_PCT = 8'h78;        // 120 %
  localparam logic [3:0] LOAD_VOLT_DEFAULT = 4'ha;     // 10 V
  localparam logic [26:0] LOAD_DIV = 27'h00004b0;      // 120 % x 10 V
  localparam logic [11:0] MS_CNT_MAX = 12'hfff;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] func;          // spindle_function_select
    logic [6:0] pct;            // deviation_width_percent
    logic [11:0] dur;           // deviation_duration_ms
    logic [3:0][11:0] mag;      // post orientation gain magnifications
    logic [11:0] shift;         // virtual_target_shift
    logic [14:0] spd_full;      // speed_meter_full_speed
    logic [3:0] load_volt;      // load_meter_full_voltage
    logic [14:0] top_spd;       // top_speed_setting
  } ssd_cfg_t;

  typedef struct packed {
    logic [15:0] speed_code;
    logic [15:0] load_code;
  } ssd_meter_t;

endpackage : ssd_pkg

// *** verilog/ssd_monitor.sv ***
// Spindle speed deviation monitor with APB settings registers.
// Assumes speed, load and orientation inputs come from logic on pclk;
// meter codes feed a DAC stage outside, 0x7fff meaning 10 V.
//
// Overview of operation
// - Width equals command times percent over hundred
// - Width below 45 r/min clamps to 45
// - Zero percent disables deviation alarm completely
// - Alarm only after excess lasts past duration
// - Zero duration raises alarm without waiting
// - Gain changeover scales four gains after orientation
// - Virtual target bit shifts orientation target
// - Speed meter full speed gives 10V code
// - Zero meter speed falls back to top speed
// - 120 percent load gives set voltage, zero=10V
// - Written settings take effect at once

`timescale 1ns/1ps

module ssd_monitor #(
  parameter int unsigned CYC_PER_MS = ssd_pkg::CYC_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [14:0] speed_cmd,
  input wire logic [14:0] speed_fb,
  input wire logic [7:0] load_pct,
  input wire logic orient_done,
  input wire logic [3:0][15:0] gain_base,
  input wire logic [11:0] orient_target,
  output logic [3:0][15:0] gain_out,
  output logic [11:0] target_out,
  output ssd_pkg::ssd_meter_t meter,
  output logic alarm,
  output logic irq
);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  ssd_pkg::ssd_cfg_t cfg_r;
  logic [1:0] int_stat_r;
  logic [1:0] int_stat_nxt;
  logic [1:0] int_mask_r;
  logic [16:0] det_width_r;
  logic alarm_r;
  logic [31:0] rdata_nxt;
  logic map_hit;
  logic setup;
  logic acc;
  logic wr_acc;
  logic rd_stat;

  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite && !pslverr;
  assign rd_stat = acc && !pwrite && (paddr == ssd_pkg::OFS_INT_STAT);

  always_comb begin
    rdata_nxt = ssd_pkg::RST_ZERO;
    map_hit = 1'b1;
    unique case (paddr)
      ssd_pkg::OFS_FUNC: rdata_nxt[15:0] = cfg_r.func;
      ssd_pkg::OFS_PCT: rdata_nxt[6:0] = cfg_r.pct;
      ssd_pkg::OFS_DUR: rdata_nxt[11:0] = cfg_r.dur;
      ssd_pkg::OFS_MAG0: rdata_nxt[11:0] = cfg_r.mag[0];
      ssd_pkg::OFS_MAG1: rdata_nxt[11:0] = cfg_r.mag[1];
      ssd_pkg::OFS_MAG2: rdata_nxt[11:0] = cfg_r.mag[2];
      ssd_pkg::OFS_MAG3: rdata_nxt[11:0] = cfg_r.mag[3];
      ssd_pkg::OFS_SHIFT: rdata_nxt[11:0] = cfg_r.shift;
      ssd_pkg::OFS_SPD_FULL: rdata_nxt[14:0] = cfg_r.spd_full;
      ssd_pkg::OFS_LOAD_VOLT: rdata_nxt[3:0] = cfg_r.load_volt;
      ssd_pkg::OFS_TOP_SPD: rdata_nxt[14:0] = cfg_r.top_spd;
      ssd_pkg::OFS_INT_STAT: rdata_nxt[1:0] = int_stat_r;
      ssd_pkg::OFS_INT_MASK: rdata_nxt[1:0] = int_mask_r;
      ssd_pkg::OFS_STATUS: rdata_nxt = {14'h0000, alarm_r, det_width_r};
      default: map_hit = 1'b0;
    endcase
  end

  // Answer prepared in setup so the access phase needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= (setup && !pwrite) ? rdata_nxt : 32'h0000_0000;
      pready <= setup;
      pslverr <= setup && !map_hit;
    end
  end

  // Settings are live the cycle after the write, no restart needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= '0;
      int_mask_r <= 2'h0;
    end else if (wr_acc) begin
      unique case (paddr)
        ssd_pkg::OFS_FUNC: cfg_r.func <= pwdata[15:0];
        ssd_pkg::OFS_PCT: cfg_r.pct <= pwdata[6:0];
        ssd_pkg::OFS_DUR: cfg_r.dur <= pwdata[11:0];
        ssd_pkg::OFS_MAG0: cfg_r.mag[0] <= pwdata[11:0];
        ssd_pkg::OFS_MAG1: cfg_r.mag[1] <= pwdata[11:0];
        ssd_pkg::OFS_MAG2: cfg_r.mag[2] <= pwdata[11:0];
        ssd_pkg::OFS_MAG3: cfg_r.mag[3] <= pwdata[11:0];
        ssd_pkg::OFS_SHIFT: cfg_r.shift <= pwdata[11:0];
        ssd_pkg::OFS_SPD_FULL: cfg_r.spd_full <= pwdata[14:0];
        ssd_pkg::OFS_LOAD_VOLT: cfg_r.load_volt <= pwdata[3:0];
        ssd_pkg::OFS_TOP_SPD: cfg_r.top_spd <= pwdata[14:0];
        ssd_pkg::OFS_INT_MASK: int_mask_r <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Deviation detection
  // ----------------------------------------------------------------
  logic [21:0] width_prod;
  logic [21:0] width_raw;
  logic [15:0] dev;
  logic over;
  logic [31:0] tick_cnt_r;
  logic [11:0] ms_cnt_r;
  logic alarm_nxt;

  assign width_prod = 22'(speed_cmd) * 22'(cfg_r.pct);
  assign width_raw = width_prod / ssd_pkg::PCT_DIV;
  assign dev = (speed_cmd >= speed_fb) ? 16'(speed_cmd - speed_fb)
                                       : 16'(speed_fb - speed_cmd);
  // Zero percent masks the comparison, so the alarm never sets
  assign over = (cfg_r.pct != 7'h00) && (17'(dev) > det_width_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_width_r <= 17'h00000;
    end else if (width_raw < 22'(ssd_pkg::WIDTH_MIN_RPM)) begin
      det_width_r <= ssd_pkg::WIDTH_MIN_RPM;
    end else begin
      det_width_r <= width_raw[16:0];
    end
  end

  // Millisecond timer runs only during continuous excess
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0000_0000;
      ms_cnt_r <= 12'h000;
    end else if (!over) begin
      tick_cnt_r <= 32'h0000_0000;
      ms_cnt_r <= 12'h000;
    end else if (tick_cnt_r == 32'(CYC_PER_MS - 1)) begin
      tick_cnt_r <= 32'h0000_0000;
      if (ms_cnt_r != ssd_pkg::MS_CNT_MAX) begin
        ms_cnt_r <= ms_cnt_r + 12'h001;
      end
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // Counts whole ms elapsed; a zero duration passes at once
  assign alarm_nxt = over && (ms_cnt_r >= cfg_r.dur);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_r <= 1'b0;
    end else begin
      alarm_r <= alarm_nxt;
    end
  end
  assign alarm = alarm_r;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // A new event in the clearing read cycle survives the clear
  always_comb begin
    int_stat_nxt = rd_stat ? 2'h0 : int_stat_r;
    int_stat_nxt[ssd_pkg::INT_ALARM_SET_BIT] |= alarm_nxt && !alarm_r;
    int_stat_nxt[ssd_pkg::INT_ALARM_CLR_BIT] |= !alarm_nxt && alarm_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= 2'h0;
      irq <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      irq <= |(int_stat_nxt & int_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Post orientation gains and virtual target
  // ----------------------------------------------------------------
  logic gain_chg;
  assign gain_chg = cfg_r.func[ssd_pkg::FUNC_GAIN_CHG_BIT] && orient_done;

  for (genvar g = 0; g < 4; g++) begin : g_gain
    logic [27:0] prod;
    logic [19:0] scaled;
    assign prod = 28'(gain_base[g]) * 28'(cfg_r.mag[g]);
    assign scaled = prod[27:ssd_pkg::MAG_SHIFT];
    // Saturate rather than wrap: a wrapped gain would collapse the loop
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gain_out[g] <= 16'h0000;
      end else if (gain_chg) begin
        gain_out[g] <= (|scaled[19:16]) ? 16'hffff : scaled[15:0];
      end else begin
        gain_out[g] <= gain_base[g];
      end
    end
  end

  // Wraps modulo one turn: the carry is dropped on purpose
  logic [12:0] tgt_sum;
  assign tgt_sum = 13'(orient_target) + 13'(cfg_r.shift);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_out <= 12'h000;
    end else if (cfg_r.func[ssd_pkg::FUNC_VTGT_BIT]) begin
      target_out <= tgt_sum[11:0];
    end else begin
      target_out <= orient_target;
    end
  end

  // ----------------------------------------------------------------
  // Meter scaling
  // ----------------------------------------------------------------
  logic [14:0] sm_full;
  logic [29:0] sm_prod;
  logic [29:0] sm_q;
  logic [3:0] ld_volt;
  logic [26:0] ld_prod;
  logic [26:0] ld_q;

  assign sm_full = (cfg_r.spd_full != 15'h0000) ? cfg_r.spd_full
                                                : cfg_r.top_spd;
  assign sm_prod = 30'(speed_fb) * 30'(ssd_pkg::METER_FULL_CODE);
  // Divider guarded; zero full scale reads as zero output
  assign sm_q = (sm_full == 15'h0000) ? 30'h0 : sm_prod / 30'(sm_full);
  assign ld_volt = (cfg_r.load_volt == 4'h0) ? ssd_pkg::LOAD_VOLT_DEFAULT
                                             : cfg_r.load_volt;
  assign ld_prod = 27'(load_pct) * 27'(ld_volt)
                 * 27'(ssd_pkg::METER_FULL_CODE);
  assign ld_q = ld_prod / ssd_pkg::LOAD_DIV;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meter <= '0;
    end else begin
      meter.speed_code <= (sm_q > 30'(ssd_pkg::METER_FULL_CODE))
          ? ssd_pkg::METER_FULL_CODE : sm_q[15:0];
      meter.load_code <= (ld_q > 27'(ssd_pkg::METER_FULL_CODE))
          ? ssd_pkg::METER_FULL_CODE : ld_q[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr_pct;
    wr_acc && (paddr == ssd_pkg::OFS_PCT);
  endsequence

  sequence s_excess_zero_dur;
    over && (cfg_r.dur == 12'h000);
  endsequence

  a_width_min: assert property ((cfg_r.pct != 7'h00) |=>
      det_width_r >= ssd_pkg::WIDTH_MIN_RPM)
    else $error("detection width below minimum");
  a_width_calc: assert property (
      (width_raw >= 22'(ssd_pkg::WIDTH_MIN_RPM)) ##1
      $stable(speed_cmd) && $stable(cfg_r.pct)
      |-> 22'(det_width_r) * ssd_pkg::PCT_DIV
          <= 22'(speed_cmd) * 22'(cfg_r.pct)
      && 22'(det_width_r) * ssd_pkg::PCT_DIV + ssd_pkg::PCT_DIV
          > 22'(speed_cmd) * 22'(cfg_r.pct))
    else $error("detection width not command times percent");
  a_zero_off: assert property ((cfg_r.pct == 7'h00) |=> !alarm_r)
    else $error("alarm with detection disabled");
  a_dur_wait: assert property ($rose(alarm_r) |->
      $past(over) && ($past(ms_cnt_r) >= $past(cfg_r.dur)))
    else $error("alarm before duration elapsed");
  a_dur_zero: assert property (s_excess_zero_dur |=> alarm_r)
    else $error("zero duration alarm delayed");
  a_timer_reset: assert property (!over |=> ms_cnt_r == 12'h000
      && tick_cnt_r == 32'h0000_0000)
    else $error("deviation timer not restarted");
  a_gain_pass: assert property (!gain_chg |=>
      gain_out[0] == $past(gain_base[0]))
    else $error("gain changed without changeover");
  a_target_shift: assert property (cfg_r.func[ssd_pkg::FUNC_VTGT_BIT] |=>
      target_out == 12'($past(orient_target) + $past(cfg_r.shift)))
    else $error("virtual target shift wrong");
  a_meter_full: assert property ((sm_full != 15'h0000)
      && (speed_fb >= sm_full) |=>
      meter.speed_code == ssd_pkg::METER_FULL_CODE)
    else $error("speed meter not full scale");
  a_meter_top: assert property ((cfg_r.spd_full == 15'h0000)
      && (cfg_r.top_spd != 15'h0000) && (speed_fb == cfg_r.top_spd) |=>
      meter.speed_code == ssd_pkg::METER_FULL_CODE)
    else $error("top speed fallback missing");
  a_load_dflt: assert property ((cfg_r.load_volt == 4'h0)
      && (load_pct == ssd_pkg::LOAD_FULL_PCT) |=>
      meter.load_code == ssd_pkg::METER_FULL_CODE)
    else $error("load meter default voltage wrong");
  a_write_live: assert property (s_wr_pct |=>
      cfg_r.pct == $past(pwdata[6:0]))
    else $error("setting not applied at once");

endmodule : ssd_monitor

// *** test/ssd_nc_model.sv ***
// Model of the numerical controller and the motor speed feedback.
// Assumes the bench posts requests on pclk; outputs are registered.
`timescale 1ns/1ps
module ssd_nc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [14:0] cmd_req,
  input wire logic [14:0] fb_req,
  input wire logic [7:0] load_req,
  input wire logic orient_req,
  output logic [14:0] speed_cmd,
  output logic [14:0] speed_fb,
  output logic [7:0] load_pct,
  output logic orient_done
);
  // Values change only at edges, as sampled drive data would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_cmd <= 15'h0000;
      speed_fb <= 15'h0000;
      load_pct <= 8'h00;
      orient_done <= 1'b0;
    end else begin
      speed_cmd <= cmd_req;
      speed_fb <= fb_req;
      load_pct <= load_req;
      orient_done <= orient_req;
    end
  end
endmodule : ssd_nc_model

// *** test/ssd_monitor_tb.sv ***
// Self-checking bench for the spindle speed deviation monitor.
// Assumes one 10 MHz clock and a shortened millisecond count.
`timescale 1ns/1ps
module ssd_monitor_tb;
  localparam int unsigned CPM = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, e;
  logic pready, pslverr, err, alarm, irq, orient_req = 1'b0, orient_done;
  logic [14:0] cmd_req = 15'h0, fb_req = 15'h0, speed_cmd, speed_fb;
  logic [7:0] load_req = 8'h00, load_pct;
  logic [3:0][15:0] gain_base = '0, gain_out;
  logic [11:0] orient_target = 12'h000, target_out;
  ssd_pkg::ssd_meter_t meter;
  int failures = 0, n_checks = 0, cyc = 0;
  int cmds[4] = '{1000, 80, 91, 32767};
  int mags[4] = '{256, 512, 2560, 0};
  always #50 pclk = ~pclk;
  ssd_nc_model nc_m (.pclk(pclk), .presetn(presetn), .cmd_req(cmd_req),
    .fb_req(fb_req), .load_req(load_req), .orient_req(orient_req),
    .speed_cmd(speed_cmd), .speed_fb(speed_fb), .load_pct(load_pct),
    .orient_done(orient_done));
  ssd_monitor #(.CYC_PER_MS(CPM)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_cmd(speed_cmd), .speed_fb(speed_fb), .load_pct(load_pct),
    .orient_done(orient_done), .gain_base(gain_base),
    .orient_target(orient_target), .gain_out(gain_out),
    .target_out(target_out), .meter(meter), .alarm(alarm), .irq(irq));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // Waits on pready; a dead slave runs into the cycle ceiling
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic nc(input int c, input int f, input int n);
    @(posedge pclk);
    cmd_req <= 15'(c);
    fb_req <= 15'(f);
    repeat (n) @(posedge pclk);
  endtask : nc
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ssd_pkg::OFS_DUR, 32'h0);
    chk("dur_reset", rd, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    apb(1'b1, ssd_pkg::OFS_PCT, 32'h32);
    for (int i = 0; i < 4; i++) begin
      nc(cmds[i], cmds[i], 3);
      apb(1'b0, ssd_pkg::OFS_STATUS, 32'h0);
      e = cmds[i] * 50 / 100;
      if (e < 45)
        e = 45;
      chk("width", {15'h0, rd[16:0]}, e);
    end
    apb(1'b1, ssd_pkg::OFS_PCT, 32'h0);
    nc(1000, 0, 10);
    chk("alarm_off", {31'h0, alarm}, 32'h0);
    apb(1'b1, ssd_pkg::OFS_INT_MASK, 32'h1);
    apb(1'b1, ssd_pkg::OFS_PCT, 32'ha);
    repeat (4) @(posedge pclk);
    chk("alarm_now", {31'h0, alarm}, 32'h1);
    chk("irq_set", {31'h0, irq}, 32'h1);
    apb(1'b0, ssd_pkg::OFS_INT_STAT, 32'h0);
    chk("stat_rose", rd, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    nc(1000, 1000, 4);
    chk("alarm_drop", {31'h0, alarm}, 32'h0);
    apb(1'b0, ssd_pkg::OFS_INT_STAT, 32'h0);
    chk("stat_fell", rd, 32'h2);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    // Second burst would reach two ms if the timer kept the first
    apb(1'b1, ssd_pkg::OFS_DUR, 32'h2);
    nc(1000, 0, 12);
    chk("alarm_wait", {31'h0, alarm}, 32'h0);
    nc(1000, 1000, 2);
    nc(1000, 0, 15);
    chk("alarm_restart", {31'h0, alarm}, 32'h0);
    repeat (12) @(posedge pclk);
    chk("alarm_late", {31'h0, alarm}, 32'h1);
    gain_base <= {16'h1000, 16'h1000, 16'h0100, 16'h0300};
    for (int i = 0; i < 4; i++)
      apb(1'b1, ssd_pkg::OFS_MAG0 + 8'(4 * i), 32'(mags[i]));
    apb(1'b1, ssd_pkg::OFS_FUNC, 32'h1000);
    repeat (2) @(posedge pclk);
    chk("gain_idle", gain_out[1], gain_base[1]);
    orient_req <= 1'b1;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      e = (32'(gain_base[i]) * 32'(mags[i])) >> 8;
      if (e > 32'hffff)
        e = 32'hffff;
      chk("gain_mag", {16'h0, gain_out[i]}, e);
    end
    orient_target <= 12'hbb8;
    apb(1'b1, ssd_pkg::OFS_SHIFT, 32'h800);
    apb(1'b1, ssd_pkg::OFS_FUNC, 32'h3000);
    repeat (2) @(posedge pclk);
    chk("target", {20'h0, target_out}, 32'h3b8);
    nc(1000, 500, 0);
    load_req <= 8'h78;
    apb(1'b1, ssd_pkg::OFS_SPD_FULL, 32'h3e8);
    repeat (2) @(posedge pclk);
    chk("spd_full", {16'h0, meter.speed_code}, 32'h3fff);
    chk("load_dflt", {16'h0, meter.load_code}, 32'h7fff);
    apb(1'b1, ssd_pkg::OFS_SPD_FULL, 32'h0);
    apb(1'b1, ssd_pkg::OFS_TOP_SPD, 32'h7d0);
    apb(1'b1, ssd_pkg::OFS_LOAD_VOLT, 32'h5);
    repeat (2) @(posedge pclk);
    chk("spd_top", {16'h0, meter.speed_code}, 32'h1fff);
    chk("load_5v", {16'h0, meter.load_code}, 32'h3fff);
    close_out();
  end
endmodule : ssd_monitor_tb
